// File: logic/ddrcs_ctrl.v
// Purpose: host-side command spacing gate for a DDR2 SDRAM
// Assumes: user offers commands with cmd_valid/cmd_code; cmd_ready
//   accepts them; accepted commands appear on mem_cmd in the same cycle as cmd_ready
// Notes: memory clock equals clk; refresh is counted, not scheduled
`timescale 1ns/10ps
`default_nettype none
`include "ddrcs_defs.vh"
module ddrcs_ctrl #(
  parameter REFRESH_CYCLE_NS = 128,
  parameter SLOW_EXIT_BASE = `DDRCS_SLOW_EXIT_BASE
) (
  input wire clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire [13:0] cmd_addr,
  input wire [2:0] additive_latency,
  input wire temp_hot,
  output reg cmd_ready,
  output reg [2:0] mem_cmd,
  output reg [13:0] mem_addr,
  output reg mem_cke,
  output reg mem_clk_en,
  output reg outputs_settled,
  output reg refresh_due,
  output reg refresh_overdue
);
  localparam [15:0] SR_NONREAD_CYC = (REFRESH_CYCLE_NS + `DDRCS_SR_EXTRA_NS
    + `DDRCS_CLK_PERIOD_NS - 1) / `DDRCS_CLK_PERIOD_NS;
  localparam [15:0] HOLD_CYC = (`DDRCS_CLOCK_HOLD_NS + `DDRCS_CLK_PERIOD_NS
    - 1) / `DDRCS_CLK_PERIOD_NS;
  localparam [15:0] SETTLE_CYC = (`DDRCS_DRIVE_CAL_OUTPUT_DELAY_NS
    + `DDRCS_CLK_PERIOD_NS - 1) / `DDRCS_CLK_PERIOD_NS;
  // Longest interval rounds down so the average never runs late
  localparam [15:0] REFI_COOL_CYC = `DDRCS_REFI_NORMAL_NS
    / `DDRCS_CLK_PERIOD_NS;
  localparam [15:0] REFI_HOT_CYC = `DDRCS_REFI_HOT_NS / `DDRCS_CLK_PERIOD_NS;
  localparam [15:0] SLOW_BASE_CYC = SLOW_EXIT_BASE;
  localparam [15:0] MRD_CYC = `DDRCS_MODE_SET_SPACING;
  localparam [15:0] SR_READ_CYC = `DDRCS_SELFREF_EXIT_READ_WAIT;
  localparam [15:0] XP_CYC = `DDRCS_PRECHARGE_PD_EXIT_WAIT;
  localparam [15:0] XARD_CYC = `DDRCS_ACTIVE_PD_FAST_EXIT_WAIT;
  localparam [15:0] CKE_CYC = `DDRCS_CKE_MIN_PULSE;
  // Low phase covers both the pulse and the clock hold
  localparam [15:0] CKE_LOW_CYC = (HOLD_CYC > CKE_CYC) ? HOLD_CYC : CKE_CYC;

  // Counter slots: 0 any command, 1 read, 2 cke pulse, 3 settle
  reg [3:0] load_r;
  reg [15:0] val0_r, val1_r, val2_r, val3_r;
  wire [3:0] done;
  wire [63:0] vals = {val3_r, val2_r, val1_r, val0_r};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
      ddrcs_down_counter u_cnt (
        .clk(clk),
        .rst_b(rst_b),
        .load(load_r[gi]),
        .load_val(vals[gi*16 +: 16]),
        .done(done[gi])
      );
    end
  endgenerate

  reg [1:0] pstate_r;
  reg slow_exit_r;
  reg [15:0] refi_cnt_r;
  reg [3:0] owed_r;
  reg [15:0] slow_cyc;
  reg accept;
  reg is_read, is_ref, is_exit, is_entry, is_mrs;

  always @* begin
    is_read = (cmd_code == `DDRCS_CMD_READ);
    is_ref = (cmd_code == `DDRCS_CMD_REFRESH);
    is_exit = (cmd_code == `DDRCS_CMD_EXIT);
    is_mrs = (cmd_code == `DDRCS_CMD_MRS);
    is_entry = (cmd_code == `DDRCS_CMD_SR_ENTER) ||
      (cmd_code == `DDRCS_CMD_PD_ENTER);
    // base minus latency, at least one
    if (SLOW_BASE_CYC > {13'h0000, additive_latency} + 16'h0001) begin
      slow_cyc = SLOW_BASE_CYC - {13'h0000, additive_latency};
    end else begin
      slow_cyc = 16'h0001;
    end
    accept = 1'b0;
    // Ready cycle refused so a held request is not taken twice
    if (cmd_valid && cmd_code != `DDRCS_CMD_NOP && load_r == 4'h0 &&
      !cmd_ready) begin
      if (pstate_r == `DDRCS_PS_ACTIVE) begin
        if (is_exit) begin
          accept = 1'b0;
        end else if (is_entry) begin
          accept = done[0] && done[1] && done[2];
        end else if (is_read) begin
          accept = done[0] && done[1];
        end else begin
          accept = done[0];
        end
      end else begin
        accept = is_exit && done[2];
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ready <= 1'b0;
      mem_cmd <= `DDRCS_CMD_NOP;
      mem_addr <= 14'h0000;
      mem_cke <= 1'b1;
      mem_clk_en <= 1'b1;
      outputs_settled <= 1'b1;
      pstate_r <= `DDRCS_PS_ACTIVE;
      slow_exit_r <= 1'b0;
      load_r <= 4'h0;
      val0_r <= 16'h0000;
      val1_r <= 16'h0000;
      val2_r <= 16'h0000;
      val3_r <= 16'h0000;
    end else begin
      load_r <= 4'h0;
      cmd_ready <= 1'b0;
      mem_cmd <= `DDRCS_CMD_NOP;
      outputs_settled <= done[3] && !load_r[3];
      if (pstate_r == `DDRCS_PS_ACTIVE || !done[2] || load_r[2]) begin
        mem_clk_en <= 1'b1;
      end else begin
        mem_clk_en <= 1'b0;
      end
      if (accept) begin
        cmd_ready <= 1'b1;
        mem_cmd <= cmd_code;
        mem_addr <= cmd_addr;
        if (is_mrs) begin
          load_r[0] <= 1'b1;
          val0_r <= MRD_CYC;
          slow_exit_r <= cmd_addr[`DDRCS_PS_A12_BIT];
          load_r[3] <= 1'b1;
          val3_r <= SETTLE_CYC;
          outputs_settled <= 1'b0;
        end else if (is_entry) begin
          mem_cke <= 1'b0;
          load_r[2] <= 1'b1;
          val2_r <= CKE_LOW_CYC;
          if (cmd_code == `DDRCS_CMD_SR_ENTER) begin
            pstate_r <= `DDRCS_PS_SELFREF;
          end else if (cmd_addr[10]) begin
            pstate_r <= `DDRCS_PS_PRE_PD;
          end else begin
            pstate_r <= `DDRCS_PS_ACT_PD;
          end
        end else if (is_exit) begin
          mem_cke <= 1'b1;
          mem_clk_en <= 1'b1;
          pstate_r <= `DDRCS_PS_ACTIVE;
          load_r <= 4'h7;
          val2_r <= CKE_CYC;
          case (pstate_r)
            `DDRCS_PS_SELFREF: begin
              val0_r <= SR_NONREAD_CYC;
              val1_r <= SR_READ_CYC;
            end
            `DDRCS_PS_PRE_PD: begin
              val0_r <= XP_CYC;
              val1_r <= XP_CYC;
            end
            `DDRCS_PS_ACT_PD: begin
              val0_r <= XP_CYC;
              val1_r <= slow_exit_r ? slow_cyc : XARD_CYC;
            end
            default: begin
              val0_r <= 16'h0001;
              val1_r <= 16'h0001;
            end
          endcase
        end
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refi_cnt_r <= 16'h0000;
      owed_r <= 4'h0;
      refresh_due <= 1'b0;
      refresh_overdue <= 1'b0;
    end else begin
      if (refi_cnt_r >= (temp_hot ? REFI_HOT_CYC : REFI_COOL_CYC) - 16'h1) begin
        refi_cnt_r <= 16'h0000;
        if (!(accept && is_ref) && owed_r != 4'hf) begin
          owed_r <= owed_r + 4'h1;
        end
      end else begin
        refi_cnt_r <= refi_cnt_r + 16'h0001;
        if (accept && is_ref && owed_r != 4'h0) begin
          owed_r <= owed_r - 4'h1;
        end
      end
      refresh_due <= owed_r != 4'h0;
      refresh_overdue <= owed_r >= `DDRCS_MAX_POSTED_REFRESH;
    end
  end
endmodule // ddrcs_ctrl
`default_nettype wire

// File: logic/ddrcs_down_counter.v
// Purpose: loadable down-counter for one spacing constraint
// Assumes: load wins over counting
// Notes: done is high while the count is zero
`timescale 1ns/10ps
`default_nettype none
module ddrcs_down_counter (
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [15:0] load_val,
  output wire done
);
  reg [15:0] cnt_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign done = (cnt_r == 16'h0000);
endmodule // ddrcs_down_counter
`default_nettype wire

// File: pkg/ddrcs_defs.vh
// Purpose: constants for the DDR2 command spacing controller
// Assumes: 100 MHz controller clock, 10 ns period
// Notes: times in ns, cycle counts derived by rounding up, except refresh intervals, rounded down
`ifndef DDRCS_DEFS_VH
`define DDRCS_DEFS_VH
`define DDRCS_CLK_PERIOD_NS 10
// Command encodings on cmd_code
`define DDRCS_CMD_NOP 3'h0
`define DDRCS_CMD_MRS 3'h1
`define DDRCS_CMD_READ 3'h2
`define DDRCS_CMD_OTHER 3'h3
`define DDRCS_CMD_REFRESH 3'h4
`define DDRCS_CMD_SR_ENTER 3'h5
`define DDRCS_CMD_PD_ENTER 3'h6
`define DDRCS_CMD_EXIT 3'h7
// Power states of the memory
`define DDRCS_PS_ACTIVE 2'h0
`define DDRCS_PS_SELFREF 2'h1
`define DDRCS_PS_PRE_PD 2'h2
`define DDRCS_PS_ACT_PD 2'h3
`define DDRCS_MODE_SET_SPACING 2
`define DDRCS_SR_EXTRA_NS 10
`define DDRCS_SELFREF_EXIT_READ_WAIT 200
`define DDRCS_PRECHARGE_PD_EXIT_WAIT 2
`define DDRCS_ACTIVE_PD_FAST_EXIT_WAIT 2
`define DDRCS_SLOW_EXIT_BASE 8
`define DDRCS_CKE_MIN_PULSE 3
// Input setup + period + hold, rounded up to whole ns
`define DDRCS_CLOCK_HOLD_NS 11
`define DDRCS_DRIVE_CAL_OUTPUT_DELAY_NS 12
`define DDRCS_TERMINATION_OUTPUT_DELAY_NS 12
`define DDRCS_REFI_NORMAL_NS 7800
`define DDRCS_REFI_HOT_NS 3900
`define DDRCS_MAX_POSTED_REFRESH 8
`define DDRCS_PS_A12_BIT 12
`define DDRCS_CNT_W 16
`endif

// File: test/ddrcs_checker.sv
// Purpose: port timing checks for the spacing gate
// Assumes: one clock, async low reset
// Notes: long waits use a saturating gap count
`timescale 1ns/10ps
`default_nettype none
`include "ddrcs_defs.vh"
module ddrcs_checker #(
  parameter REFRESH_CYCLE_NS = 128,
  parameter SLOW_EXIT_BASE = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] mem_cmd,
  input wire logic [13:0] mem_addr,
  input wire logic [2:0] additive_latency,
  input wire logic mem_cke,
  input wire logic mem_clk_en
);
  localparam int XS = (REFRESH_CYCLE_NS + 19) / 10;
  logic [7:0] gap_r;
  logic [1:0] kind_r;
  logic slow_r;
  wire rd = mem_cmd == `DDRCS_CMD_READ;
  wire nrd = !rd && mem_cmd != `DDRCS_CMD_NOP;
  // Saturates so old exits never wrap into false alarms
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_r <= 8'hff;
      kind_r <= 2'h0;
      slow_r <= 1'b0;
    end else begin
      if (mem_cmd == `DDRCS_CMD_EXIT)
        gap_r <= 8'h01;
      else if (gap_r != 8'hff)
        gap_r <= gap_r + 8'h01;
      if (mem_cmd == `DDRCS_CMD_SR_ENTER)
        kind_r <= 2'h1;
      if (mem_cmd == `DDRCS_CMD_PD_ENTER)
        kind_r <= mem_addr[10] ? 2'h2 : 2'h3;
      if (mem_cmd == `DDRCS_CMD_MRS)
        slow_r <= mem_addr[12];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_idle2;
    mem_cmd == `DDRCS_CMD_NOP ##1 mem_cmd == `DDRCS_CMD_NOP;
  endsequence
  a_mrs_gap: assert property (
    mem_cmd == `DDRCS_CMD_MRS |=> s_idle2) else $error("mode set gap");
  a_sr_nonread: assert property (
    nrd && kind_r == 2'h1 |-> gap_r >= XS) else $error("sr exit gap");
  a_sr_read: assert property (
    rd && kind_r == 2'h1 |-> gap_r >= 8'hc8) else $error("sr read gap");
  a_pd_exit: assert property (
    nrd && kind_r == 2'h2 |-> gap_r >= 8'h02) else $error("pd exit gap");
  a_fast_read: assert property (
    rd && kind_r == 2'h3 && !slow_r |-> gap_r >= 8'h02)
    else $error("fast exit gap");
  a_slow_read: assert property (
    rd && kind_r == 2'h3 && slow_r |->
    gap_r + additive_latency >= SLOW_EXIT_BASE) else $error("slow exit gap");
  a_clk_hold: assert property (
    $fell(mem_cke) |-> mem_clk_en ##1 mem_clk_en) else $error("clock hold");
  a_cke_pulse: assert property (
    $changed(mem_cke) |=> $stable(mem_cke) [*2]) else $error("cke pulse");
endmodule // ddrcs_checker
bind ddrcs_ctrl ddrcs_checker #(.REFRESH_CYCLE_NS(REFRESH_CYCLE_NS),
  .SLOW_EXIT_BASE(SLOW_EXIT_BASE)) ddrcs_checker_inst (.clk(clk),
  .rst_b(rst_b), .mem_cmd(mem_cmd), .mem_addr(mem_addr), .mem_cke(mem_cke),
  .additive_latency(additive_latency), .mem_clk_en(mem_clk_en));
`default_nettype wire

// File: test/ddrcs_mem_model.sv
// Purpose: device side of the spacing gate
// Assumes: memory clock equals clk
// Notes: keeps only the exit mode state
`timescale 1ns/10ps
`default_nettype none
`include "ddrcs_defs.vh"
module ddrcs_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] mem_cmd,
  input wire logic [13:0] mem_addr,
  output logic slow_exit_r
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      slow_exit_r <= 1'b0;
    else if (mem_cmd == `DDRCS_CMD_MRS)
      slow_exit_r <= mem_addr[12];
  end
endmodule // ddrcs_mem_model
`default_nettype wire

// File: test/tb.sv
// Purpose: directed bench for the spacing gate
// Assumes: refresh cycle 128 ns, grade base 8, latency 2
// Notes: spacings allow a few cycles of slack
`timescale 1ns/10ps
`default_nettype none
`include "ddrcs_defs.vh"
module tb;
  logic clk, rst_b, cmd_valid, temp_hot, cmd_ready, mem_cke, slow_exit_r;
  logic mem_clk_en, outputs_settled, refresh_due, refresh_overdue;
  logic [2:0] cmd_code, additive_latency, mem_cmd;
  logic [13:0] cmd_addr, mem_addr;
  int error_cnt, checked, cyc, t_acc, t_prev;
  ddrcs_ctrl ddrcs_ctrl_inst (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
    .additive_latency(additive_latency), .temp_hot(temp_hot),
    .cmd_ready(cmd_ready), .mem_cmd(mem_cmd), .mem_addr(mem_addr),
    .mem_cke(mem_cke), .mem_clk_en(mem_clk_en),
    .outputs_settled(outputs_settled), .refresh_due(refresh_due),
    .refresh_overdue(refresh_overdue));
  ddrcs_mem_model ddrcs_mem_model_inst (.clk(clk), .rst_b(rst_b),
    .mem_cmd(mem_cmd), .mem_addr(mem_addr), .slow_exit_r(slow_exit_r));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst_run(input logic h);
    @(posedge clk);
    rst_b <= 1'b0;
    temp_hot <= h;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  // Valid held through the ready cycle, which the gate refuses
  task automatic send(input logic [2:0] c, input logic [13:0] a);
    int n;
    n = 0;
    @(posedge clk);
    cmd_code <= c;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    chk_rng(n, 1, 499);
    t_prev = t_acc;
    t_acc = cyc;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic t_mrs(input logic [13:0] a);
    send(`DDRCS_CMD_MRS, a);
    chk_bit(outputs_settled, 1'b0);
    send(`DDRCS_CMD_OTHER, 14'h0000);
    chk_rng(t_acc - t_prev, 2, 5);
    chk_bit(outputs_settled, 1'b1);
    chk_bit(slow_exit_r, a[12]);
  endtask
  task automatic t_exit(input logic [2:0] e, input logic [13:0] a,
    input logic [2:0] x, input int lo);
    send(e, a);
    idle(1);
    chk_bit(mem_cke, 1'b0);
    send(`DDRCS_CMD_EXIT, 14'h0000);
    send(x, 14'h0000);
    chk_rng(t_acc - t_prev, lo, lo + 4);
  endtask
  initial begin
    {rst_b, cmd_valid, temp_hot, cmd_code, cmd_addr} = '0;
    additive_latency = 3'h2;
    rst_run(1'b0);
    idle(770);
    chk_bit(refresh_due, 1'b0);
    idle(20);
    chk_bit(refresh_due, 1'b1);
    rst_run(1'b1);
    idle(380);
    chk_bit(refresh_due, 1'b0);
    idle(20);
    chk_bit(refresh_due, 1'b1);
    idle(2700);
    chk_bit(refresh_overdue, 1'b0);
    idle(40);
    chk_bit(refresh_overdue, 1'b1);
    repeat (8) send(`DDRCS_CMD_REFRESH, 14'h0000);
    chk_bit(refresh_due, 1'b0);
    t_mrs(14'h0000);
    t_exit(`DDRCS_CMD_PD_ENTER, 14'h0400, `DDRCS_CMD_OTHER, 2);
    t_exit(`DDRCS_CMD_PD_ENTER, 14'h0000, `DDRCS_CMD_READ, 2);
    t_mrs(14'h1000);
    t_exit(`DDRCS_CMD_PD_ENTER, 14'h0000, `DDRCS_CMD_READ, 6);
    t_exit(`DDRCS_CMD_SR_ENTER, 14'h0000, `DDRCS_CMD_OTHER, 14);
    t_exit(`DDRCS_CMD_SR_ENTER, 14'h0000, `DDRCS_CMD_READ, 200);
    complete_run();
  end
endmodule // tb
`default_nettype wire
